// file: core/susc_pkg.sv
package susc_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite bus)
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_CORE = 4'h8;
   localparam int ADDR_W = 4;

   // ------------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------------
   localparam int ST_START = 7;
   localparam int ST_OVF = 6;
   localparam int ST_STOP = 5;
   localparam int ST_COLL = 4;
   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int CT_SIE = 7;
   localparam int CT_OIE = 6;
   localparam int CT_WM_HI = 5;
   localparam int CT_WM_LO = 4;
   localparam int CT_CS_HI = 3;
   localparam int CT_CS_LO = 2;
   localparam int CT_CLK = 1;
   localparam int CT_TC = 0;

   // Core-side register at ADDR_CORE: bit 0 global interrupt enable.
   localparam int CR_GIE = 0;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SUSC_WM_OFF = 2'h0,
      SUSC_WM_THREE = 2'h1,
      SUSC_WM_TWO = 2'h2,
      SUSC_WM_RSVD = 2'h3
   } susc_wm_e;

   localparam logic [1:0] CS_SOFT = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;
endpackage

// file: core/susc_top.sv
`timescale 1ns/1ps
module susc_top
   import susc_pkg::*;
(
   input wire logic CORE_CLK, // System clock, 20 MHz.
   input wire logic RST, // Asynchronous reset, active high.
   input wire logic [susc_pkg::ADDR_W-1:0] S_AXI_AWADDR, // Write address.
   input wire logic S_AXI_AWVALID, // Write address valid.
   output logic S_AXI_AWREADY, // Write address ready.
   input wire logic [31:0] S_AXI_WDATA, // Write data.
   input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
   input wire logic S_AXI_WVALID, // Write data valid.
   output logic S_AXI_WREADY, // Write data ready.
   output logic [1:0] S_AXI_BRESP, // Write response.
   output logic S_AXI_BVALID, // Write response valid.
   input wire logic S_AXI_BREADY, // Write response ready.
   input wire logic [susc_pkg::ADDR_W-1:0] S_AXI_ARADDR, // Read address.
   input wire logic S_AXI_ARVALID, // Read address valid.
   output logic S_AXI_ARREADY, // Read address ready.
   output logic [31:0] S_AXI_RDATA, // Read data.
   output logic [1:0] S_AXI_RRESP, // Read response.
   output logic S_AXI_RVALID, // Read data valid.
   input wire logic S_AXI_RREADY, // Read data ready.
   input wire logic SERIAL_CLOCK_PIN, // Sampled clock line level.
   input wire logic DATA_IN_PIN, // Sampled data line level.
   input wire logic SHIFT_MSB, // Bit 7 of the shift register.
   input wire logic TIMER_MATCH, // Timer 0 compare match pulse.
   input wire logic CLK_OUT_ENABLE, // Port direction bit of the clock pin.
   output logic HELD_CLOCK_LINE_OE, // High while the clock line is forced low.
   output logic HELD_CLOCK_LINE_O, // Level driven while enabled, always low.
   output logic COUNTER_CLOCK, // One-cycle counter clock, also shifts the data path.
   output logic START_IRQ, // Start condition interrupt request.
   output logic OVERFLOW_IRQ, // Counter overflow interrupt request.
   output logic WAKE_ANY_SLEEP, // Wake request valid in every sleep mode.
   output logic WAKE_IDLE_SLEEP // Wake request valid in idle sleep only.
);
   import susc_pkg::*;

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic start_condition_flag_r;
   logic counter_overflow_flag_r;
   logic stop_condition_flag_r;
   logic [CNT_W-1:0] transfer_counter_value_r;
   logic [CNT_W-1:0] count_nxt;
   logic start_interrupt_enable_r;
   logic overflow_interrupt_enable_r;
   logic [1:0] wire_mode_select_r;
   logic [1:0] clock_source_select_r;
   logic clock_strobe_select_r;
   logic global_int_enable_r;
   logic start_hold_r;
   logic ovf_hold_r;
   logic scl_d_r;
   logic sda_d_r;

   // ------------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane_r;
   logic wr_fire;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= S_AXI_AWADDR;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         w_held_r <= 1'b0;
         w_byte_r <= REG_RESET;
         w_lane_r <= 1'b0;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held_r <= 1'b1;
         w_byte_r <= S_AXI_WDATA[7:0];
         w_lane_r <= S_AXI_WSTRB[0];
      end
   end

   // Both halves captured and no response outstanding: commit the write.
   assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
      end else begin
         S_AXI_AWREADY <= !aw_held_r && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID && !wr_fire;
         S_AXI_WREADY <= !w_held_r && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID && !wr_fire;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= (aw_addr_r == ADDR_STATUS || aw_addr_r == ADDR_CONTROL || aw_addr_r == ADDR_CORE)
            ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Byte lane 0 carries every register; other lanes are ignored.
   logic wr_status;
   logic wr_control;
   logic wr_core;
   assign wr_status = wr_fire && w_lane_r && aw_addr_r == ADDR_STATUS;
   assign wr_control = wr_fire && w_lane_r && aw_addr_r == ADDR_CONTROL;
   assign wr_core = wr_fire && w_lane_r && aw_addr_r == ADDR_CORE;

   // ------------------------------------------------------------------
   // Line sampling and condition detectors
   // ------------------------------------------------------------------
   // Inputs are sampled the same way in every wire mode.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= SERIAL_CLOCK_PIN;
         sda_d_r <= DATA_IN_PIN;
      end
   end

   logic two_wire;
   logic scl_edge;
   logic start_det;
   logic stop_det;
   assign two_wire = wire_mode_select_r == SUSC_WM_TWO;
   assign scl_edge = scl_d_r != SERIAL_CLOCK_PIN;
   // Data falls / rises while the clock stays high.
   assign start_det = two_wire && scl_d_r && SERIAL_CLOCK_PIN && sda_d_r && !DATA_IN_PIN;
   assign stop_det = two_wire && scl_d_r && SERIAL_CLOCK_PIN && !sda_d_r && DATA_IN_PIN;

   logic edge_start;
   assign edge_start = (wire_mode_select_r == SUSC_WM_OFF || wire_mode_select_r == SUSC_WM_THREE)
      && clock_source_select_r == CS_SOFT && !clock_strobe_select_r && scl_edge;

   // ------------------------------------------------------------------
   // Counter clock selection
   // ------------------------------------------------------------------
   logic ext_src;
   logic cnt_tick;
   logic strobe_clk;
   logic toggle_clk;
   assign ext_src = clock_source_select_r[1];
   assign strobe_clk = wr_control && w_byte_r[CT_CLK] && w_byte_r[CT_CS_HI:CT_CS_LO] == CS_SOFT;
   assign toggle_clk = wr_control && w_byte_r[CT_TC] && w_byte_r[CT_CS_HI] && w_byte_r[CT_CLK];

   // External edges count regardless of wire mode; both edges count.
   // Strobes are judged by the byte being written, so a write that also
   // changes the clock source still clocks the counter once.
   always_comb begin
      cnt_tick = strobe_clk || toggle_clk;
      if (ext_src) begin
         cnt_tick = cnt_tick || scl_edge;
      end else if (clock_source_select_r == CS_TIMER) begin
         cnt_tick = cnt_tick || TIMER_MATCH;
      end
   end

   assign count_nxt = transfer_counter_value_r + CNT_ONE;

   // A software write of the count wins over a simultaneous tick.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         transfer_counter_value_r <= '0;
      end else if (wr_status) begin
         transfer_counter_value_r <= w_byte_r[CNT_W-1:0];
      end else if (cnt_tick) begin
         transfer_counter_value_r <= count_nxt;
      end
   end

   logic ovf_event;
   assign ovf_event = cnt_tick && !wr_status && transfer_counter_value_r == CNT_MAX;

   // ------------------------------------------------------------------
   // Flags: hardware set wins over a same-cycle clear; a status write suppresses the overflow set
   // ------------------------------------------------------------------
   logic clr_start;
   logic clr_ovf;
   assign clr_start = wr_status && w_byte_r[ST_START];
   assign clr_ovf = wr_status && w_byte_r[ST_OVF];

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         start_condition_flag_r <= 1'b0;
      end else if (start_det || edge_start) begin
         start_condition_flag_r <= 1'b1;
      end else if (clr_start) begin
         start_condition_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         counter_overflow_flag_r <= 1'b0;
      end else if (ovf_event) begin
         counter_overflow_flag_r <= 1'b1;
      end else if (clr_ovf) begin
         counter_overflow_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         stop_condition_flag_r <= 1'b0;
      end else if (stop_det) begin
         stop_condition_flag_r <= 1'b1;
      end else if (wr_status && w_byte_r[ST_STOP]) begin
         stop_condition_flag_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Clock-line hold
   // ------------------------------------------------------------------
   // The start hold is armed on the start and applies once the master
   // pulls the clock low, so the start itself is never stretched.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         start_hold_r <= 1'b0;
      end else if (!two_wire) begin
         start_hold_r <= 1'b0;
      end else if (start_det) begin
         start_hold_r <= 1'b1;
      end else if (clr_start) begin
         start_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ovf_hold_r <= 1'b0;
      end else if (!two_wire) begin
         ovf_hold_r <= 1'b0;
      end else if (ovf_event) begin
         ovf_hold_r <= 1'b1;
      end else if (clr_ovf) begin
         ovf_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         HELD_CLOCK_LINE_OE <= 1'b0;
         HELD_CLOCK_LINE_O <= 1'b0;
      end else begin
         HELD_CLOCK_LINE_OE <= CLK_OUT_ENABLE && ((start_hold_r && !SERIAL_CLOCK_PIN) || ovf_hold_r)
            && !clr_start && !(clr_ovf && !start_hold_r);
         HELD_CLOCK_LINE_O <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Control and core registers
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         start_interrupt_enable_r <= 1'b0;
         overflow_interrupt_enable_r <= 1'b0;
         wire_mode_select_r <= SUSC_WM_OFF;
         clock_source_select_r <= CS_SOFT;
         clock_strobe_select_r <= 1'b0;
      end else if (wr_control) begin
         start_interrupt_enable_r <= w_byte_r[CT_SIE];
         overflow_interrupt_enable_r <= w_byte_r[CT_OIE];
         wire_mode_select_r <= w_byte_r[CT_WM_HI:CT_WM_LO];
         clock_source_select_r <= w_byte_r[CT_CS_HI:CT_CS_LO];
         clock_strobe_select_r <= w_byte_r[CT_CLK];
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         global_int_enable_r <= 1'b0;
      end else if (wr_core) begin
         global_int_enable_r <= w_byte_r[CR_GIE];
      end
   end

   // ------------------------------------------------------------------
   // Interrupts, wake requests and counter clock
   // ------------------------------------------------------------------
   // Level outputs: a flag already pending raises its request as soon as
   // both enables are set.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         START_IRQ <= 1'b0;
         OVERFLOW_IRQ <= 1'b0;
         WAKE_ANY_SLEEP <= 1'b0;
         WAKE_IDLE_SLEEP <= 1'b0;
         COUNTER_CLOCK <= 1'b0;
      end else begin
         START_IRQ <= start_condition_flag_r && start_interrupt_enable_r && global_int_enable_r;
         OVERFLOW_IRQ <= counter_overflow_flag_r && overflow_interrupt_enable_r && global_int_enable_r;
         WAKE_ANY_SLEEP <= start_condition_flag_r && start_interrupt_enable_r && global_int_enable_r;
         WAKE_IDLE_SLEEP <= counter_overflow_flag_r && overflow_interrupt_enable_r && global_int_enable_r;
         COUNTER_CLOCK <= cnt_tick;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------------
   logic [7:0] status_view;
   assign status_view = {start_condition_flag_r, counter_overflow_flag_r, stop_condition_flag_r,
      SHIFT_MSB != DATA_IN_PIN, transfer_counter_value_r};

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= RESP_OKAY;
      end else if (S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b0;
         if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= RESP_OKAY;
         // Strobe bits always read back as zero.
         case (S_AXI_ARADDR)
            ADDR_STATUS: S_AXI_RDATA <= {24'h000000, status_view};
            ADDR_CONTROL: S_AXI_RDATA <= {24'h000000, start_interrupt_enable_r, overflow_interrupt_enable_r,
               wire_mode_select_r, clock_source_select_r, 2'h0};
            ADDR_CORE: S_AXI_RDATA <= {31'h00000000, global_int_enable_r};
            default: begin
               S_AXI_RDATA <= '0;
               S_AXI_RRESP <= RESP_SLVERR;
            end
         endcase
      end else begin
         S_AXI_ARREADY <= 1'b1;
      end
   end
endmodule // susc_top

// file: sim/susc_monitor.sv
`timescale 1ns/1ps
module susc_monitor
   import susc_pkg::*;
(
   input wire logic CORE_CLK, // Clock.
   input wire logic RST, // Reset.
   input wire logic [susc_pkg::ADDR_W-1:0] S_AXI_AWADDR, // Write address.
   input wire logic S_AXI_AWVALID, // AW valid.
   input wire logic S_AXI_AWREADY, // AW ready.
   input wire logic [31:0] S_AXI_WDATA, // Write data.
   input wire logic [3:0] S_AXI_WSTRB, // Strobes.
   input wire logic S_AXI_WVALID, // W valid.
   input wire logic S_AXI_WREADY, // W ready.
   input wire logic [1:0] S_AXI_BRESP, // B code.
   input wire logic S_AXI_BVALID, // B valid.
   input wire logic S_AXI_BREADY, // B ready.
   input wire logic S_AXI_ARVALID, // AR valid.
   input wire logic S_AXI_ARREADY, // AR ready.
   input wire logic [31:0] S_AXI_RDATA, // Read data.
   input wire logic S_AXI_RVALID, // R valid.
   input wire logic S_AXI_RREADY, // R ready.
   input wire logic CLK_OUT_ENABLE, // Pin direction.
   input wire logic HELD_CLOCK_LINE_OE, // Hold enable.
   input wire logic HELD_CLOCK_LINE_O, // Hold level.
   input wire logic START_IRQ, // Start request.
   input wire logic OVERFLOW_IRQ, // Overflow request.
   input wire logic WAKE_ANY_SLEEP, // Deep wake.
   input wire logic WAKE_IDLE_SLEEP // Idle wake.
);
   import susc_pkg::*;
   logic wr_both;
   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // Only same-cycle address and data acceptance arms the timed write checks, which keeps them exact.
   assign wr_both = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   wr_answer_a: assert property (wr_both |-> ##[1:3] S_AXI_BVALID)
      else $error("write response late");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:3] S_AXI_RVALID)
      else $error("read response late");
   busy_refuse_a: assert property ((S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) and (S_AXI_RVALID |-> !S_AXI_ARREADY))
      else $error("request taken while busy");
   hold_low_a: assert property (HELD_CLOCK_LINE_OE |-> !HELD_CLOCK_LINE_O)
      else $error("held clock line not driven low");
   hold_gate_a: assert property (!CLK_OUT_ENABLE ##1 !CLK_OUT_ENABLE |-> !HELD_CLOCK_LINE_OE)
      else $error("clock held with output disabled");
   hold_release_a: assert property (wr_both && S_AXI_AWADDR == ADDR_STATUS && S_AXI_WSTRB[0] && S_AXI_WDATA[7:6] == 2'b11
      |-> ##[1:3] !HELD_CLOCK_LINE_OE)
      else $error("clock hold not released by flag clear");
   irq_off_a: assert property (wr_both && S_AXI_AWADDR == ADDR_CORE && S_AXI_WSTRB[0] && !S_AXI_WDATA[0]
      |-> ##[1:4] !START_IRQ && !OVERFLOW_IRQ)
      else $error("request stays with global enable off");
   wake_any_a: assert property (WAKE_ANY_SLEEP == START_IRQ)
      else $error("deep wake differs from start request");
   wake_idle_a: assert property (WAKE_IDLE_SLEEP == OVERFLOW_IRQ)
      else $error("idle wake differs from overflow request");
   cover property (START_IRQ);
   cover property (OVERFLOW_IRQ);
   cover property (HELD_CLOCK_LINE_OE);
endmodule // susc_monitor

bind susc_top susc_monitor u_monitor (.CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .CLK_OUT_ENABLE(CLK_OUT_ENABLE),
   .HELD_CLOCK_LINE_OE(HELD_CLOCK_LINE_OE), .HELD_CLOCK_LINE_O(HELD_CLOCK_LINE_O), .START_IRQ(START_IRQ),
   .OVERFLOW_IRQ(OVERFLOW_IRQ), .WAKE_ANY_SLEEP(WAKE_ANY_SLEEP), .WAKE_IDLE_SLEEP(WAKE_IDLE_SLEEP));

// file: sim/susc_peer.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// Serial bus peer with open-drain lines and pull-ups
// --------------------------------------------------------------
module susc_peer (
   input wire logic clk, // Bench clock.
   input wire logic hold_oe, // Clock hold from the unit.
   output logic scl, // Resolved clock line.
   output logic sda // Resolved data line.
);
   logic scl_drv = 1'b1;
   logic sda_drv = 1'b1;
   // A released line floats high, but the unit's hold always wins.
   assign scl = scl_drv & ~hold_oe;
   assign sda = sda_drv;
   // Each level stays for several cycles so the unit samples it at least twice.
   task automatic set_lines(input logic c, input logic d);
      @(posedge clk);
      scl_drv <= c;
      sda_drv <= d;
      repeat (3) @(posedge clk);
   endtask
endmodule // susc_peer

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import susc_pkg::*;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic scl, sda, shift_msb, timer_match, clk_oe_en, hold_oe, hold_o, cnt_clk;
   logic start_irq, ovf_irq, wake_any, wake_idle;
   int error_cnt = 0;
   int checks = 0;
   int cc_n = 0;
   susc_top DUT (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SERIAL_CLOCK_PIN(scl),
      .DATA_IN_PIN(sda), .SHIFT_MSB(shift_msb), .TIMER_MATCH(timer_match), .CLK_OUT_ENABLE(clk_oe_en),
      .HELD_CLOCK_LINE_OE(hold_oe), .HELD_CLOCK_LINE_O(hold_o), .COUNTER_CLOCK(cnt_clk),
      .START_IRQ(start_irq), .OVERFLOW_IRQ(ovf_irq), .WAKE_ANY_SLEEP(wake_any), .WAKE_IDLE_SLEEP(wake_idle));
   susc_peer peer (.clk(clk), .hold_oe(hold_oe), .scl(scl), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cnt_clk === 1'b1) cc_n <= cc_n + 1;
   end
   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, e});
      if (n == 40) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task automatic axr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rdata, {24'h000000, d});
      chk({30'h0, rresp}, {30'h0, e});
      if (n == 40) begin
         error_cnt++;
         finish_test();
      end
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      chk({hold_oe, start_irq, ovf_irq, cnt_clk}, 4'h0);
      axr(ADDR_STATUS, 8'h00, RESP_OKAY);
      axr(ADDR_CONTROL, 8'h00, RESP_OKAY);
      axr(ADDR_CORE, 8'h00, RESP_OKAY);
      axr(4'hC, 8'h00, RESP_SLVERR);
      axw(4'hC, 8'hFF, RESP_SLVERR);
      axw(ADDR_STATUS, 8'h10, RESP_OKAY);
      axr(ADDR_STATUS, 8'h00, RESP_OKAY);
      axw(ADDR_CONTROL, 8'h03, RESP_OKAY);
      axr(ADDR_CONTROL, 8'h00, RESP_OKAY);
      axr(ADDR_STATUS, 8'h01, RESP_OKAY);
      chk(cc_n, 1);
      axw(ADDR_STATUS, 8'h00, RESP_OKAY);
   endtask
   task automatic t_two_wire();
      @(posedge clk);
      clk_oe_en <= 1'b1;
      shift_msb <= 1'b0;
      axw(ADDR_CONTROL, 8'h20, RESP_OKAY);
      peer.set_lines(1'b1, 1'b0);
      peer.set_lines(1'b0, 1'b0);
      peer.set_lines(1'b1, 1'b0);
      settle();
      chk({hold_oe, scl}, 2'b10);
      axr(ADDR_STATUS, 8'h80, RESP_OKAY);
      axw(ADDR_STATUS, 8'h00, RESP_OKAY);
      axr(ADDR_STATUS, 8'h80, RESP_OKAY);
      axw(ADDR_STATUS, 8'hC0, RESP_OKAY);
      settle();
      chk({hold_oe, scl}, 2'b01);
      peer.set_lines(1'b1, 1'b1);
      axr(ADDR_STATUS, 8'h30, RESP_OKAY);
      axw(ADDR_STATUS, 8'h20, RESP_OKAY);
      @(posedge clk);
      shift_msb <= 1'b1;
      axr(ADDR_STATUS, 8'h00, RESP_OKAY);
   endtask
   task automatic t_overflow();
      axw(ADDR_CONTROL, 8'h00, RESP_OKAY);
      axw(ADDR_STATUS, 8'h0E, RESP_OKAY);
      axr(ADDR_STATUS, 8'h0E, RESP_OKAY);
      axw(ADDR_CONTROL, 8'h02, RESP_OKAY);
      axw(ADDR_CONTROL, 8'h02, RESP_OKAY);
      axr(ADDR_STATUS, 8'h40, RESP_OKAY);
      axw(ADDR_CONTROL, 8'h40, RESP_OKAY);
      axw(ADDR_CORE, 8'h01, RESP_OKAY);
      settle();
      chk({ovf_irq, wake_idle, start_irq, wake_any}, 4'hC);
      axw(ADDR_STATUS, 8'h00, RESP_OKAY);
      settle();
      chk(ovf_irq, 1'b1);
      axw(ADDR_STATUS, 8'h40, RESP_OKAY);
      settle();
      chk(ovf_irq, 1'b0);
   endtask
   task automatic t_edge_start();
      axw(ADDR_CONTROL, 8'h80, RESP_OKAY);
      peer.set_lines(1'b0, 1'b1);
      peer.set_lines(1'b1, 1'b1);
      settle();
      chk({start_irq, wake_any, ovf_irq}, 3'b110);
      axr(ADDR_STATUS, 8'h80, RESP_OKAY);
      axw(ADDR_CORE, 8'h00, RESP_OKAY);
      settle();
      chk(start_irq, 1'b0);
      axw(ADDR_STATUS, 8'h80, RESP_OKAY);
   endtask
   task automatic t_count_src();
      int c0;
      c0 = cc_n;
      axw(ADDR_CONTROL, 8'h08, RESP_OKAY);
      peer.set_lines(1'b0, 1'b1);
      peer.set_lines(1'b1, 1'b1);
      axr(ADDR_STATUS, 8'h02, RESP_OKAY);
      axw(ADDR_CONTROL, 8'h14, RESP_OKAY);
      @(posedge clk);
      timer_match <= 1'b1;
      @(posedge clk);
      timer_match <= 1'b0;
      axw(ADDR_CONTROL, 8'h1B, RESP_OKAY);
      axr(ADDR_STATUS, 8'h04, RESP_OKAY);
      chk(cc_n - c0, 4);
   endtask
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, timer_match, clk_oe_en} = 7'h00;
      shift_msb = 1'b1;
      awaddr = 4'h0;
      araddr = 4'h0;
      wstrb = 4'hF;
      wdata = 32'h00000000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      settle();
      t_reset();
      t_two_wire();
      t_overflow();
      t_edge_start();
      t_count_src();
      finish_test();
   end
endmodule // tb_top
